// ---- rtl/crt_pkg.sv ----
// constants for the capture/compare timer and pin routing block
// assumes one 20 MHz system clock shared by timers, modules and software port
package crt_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int unsigned CRT_NUM_MOD   = 5;
  localparam int unsigned CRT_TMR_W     = 16;
  localparam int unsigned CRT_ADDR_W    = 8;
  localparam int unsigned CRT_DATA_W    = 8;

  // ------------------------------------------------------------
  // register offsets and fields
  // ------------------------------------------------------------
  localparam logic [7:0] CRT_TMR3_CTRL_OFS = 8'h00;
  localparam logic [7:0] CRT_STATUS_OFS    = 8'h01;
  localparam int unsigned CRT_SEL_LSB      = 1;
  localparam int unsigned CRT_SEL_MSB      = 2;
  localparam int unsigned CRT_ST_USED_LSB  = 0;
  localparam int unsigned CRT_ST_PIN_BIT   = 4;
  localparam int unsigned CRT_ST_MCU_BIT   = 5;

  // ------------------------------------------------------------
  // timer select codes and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] CRT_SEL_ALL_A  = 2'h0;
  localparam logic [1:0] CRT_SEL_ONE_A  = 2'h1;
  localparam logic [1:0] CRT_SEL_TWO_A  = 2'h2;
  localparam logic [1:0] CRT_SEL_ALL_B  = 2'h3;
  localparam logic [1:0] CRT_SEL_RST    = 2'h0;
  localparam logic       CRT_PINSEL_RST = 1'b1;
  localparam logic [4:0] CRT_PAIRB_ALL_A = 5'h00;
  localparam logic [4:0] CRT_PAIRB_ONE_A = 5'h1E;
  localparam logic [4:0] CRT_PAIRB_TWO_A = 5'h1C;
  localparam logic [4:0] CRT_PAIRB_ALL_B = 5'h1F;

  // timer used bit order
  localparam int unsigned CRT_T_CAP_A = 0;
  localparam int unsigned CRT_T_PWM_A = 1;
  localparam int unsigned CRT_T_CAP_B = 2;
  localparam int unsigned CRT_T_PWM_B = 3;

  // pin route
  typedef enum logic [1:0] {
    crt_pin_c1,
    crt_pin_e7,
    crt_pin_e3
  } crt_pin_t;

endpackage : crt_pkg

// ---- rtl/crt_sync2.sv ----
// two-flop synchroniser for pin levels
// assumes inputs are quasi-static levels from pads
`timescale 1ns/100ps
`default_nettype none
module crt_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : crt_sync2
`default_nettype wire

// ---- rtl/crt_pair_map.sv ----
// maps the timer select code and module modes to timer pair and timer use
// assumes module 0 is enh_module_one and module 1 is enh_module_two
`timescale 1ns/100ps
`default_nettype none
module crt_pair_map
  import crt_pkg::*;
(
  input  wire logic [1:0] sel_i,
  input  wire logic [4:0] pwm_i,
  input  wire logic [4:0] en_i,
  output logic      [4:0] pairb_o,
  output logic      [3:0] used_o
);
  always_comb begin
    case (sel_i)
      CRT_SEL_ALL_A: pairb_o = CRT_PAIRB_ALL_A;
      CRT_SEL_ONE_A: pairb_o = CRT_PAIRB_ONE_A;
      CRT_SEL_TWO_A: pairb_o = CRT_PAIRB_TWO_A;
      CRT_SEL_ALL_B: pairb_o = CRT_PAIRB_ALL_B;
      default:       pairb_o = CRT_PAIRB_ALL_A;
    endcase
    // one timer per class and pair, shared by every module that picks it
    used_o[CRT_T_CAP_A] = |(en_i & ~pwm_i & ~pairb_o);
    used_o[CRT_T_PWM_A] = |(en_i &  pwm_i & ~pairb_o);
    used_o[CRT_T_CAP_B] = |(en_i & ~pwm_i &  pairb_o);
    used_o[CRT_T_PWM_B] = |(en_i &  pwm_i &  pairb_o);
  end
endmodule : crt_pair_map
`default_nettype wire

// ---- rtl/crt_route_top.sv ----
// capture/compare module time base routing and second enhanced module pin routing
// assumes timers, modules and software port run on clk_i; pins and straps are async
//
// Overview of operation
// - capture/compare use capture timers, PWM pwm timers
// - capture_timer_b_control field ccp_timer_select picks pairs
// - up to four timers, same class shares
// - select 00: everything on first pair
// - select 00: second pair timers unused
// - select 01: only module one on first pair
// - select 01: others share second pair
// - select 10: modules one, two first pair
// - select 11: everything on second pair
// - select 11: first pair timers unused
// - pin select set: module two on port C1
// - pin select clear: E7 microcontroller, else E3
`timescale 1ns/100ps
`default_nettype none
module crt_route_top
  import crt_pkg::*;
#(
  parameter int unsigned TMR_W = CRT_TMR_W
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [CRT_ADDR_W-1:0]       addr_i,
  input  wire logic [CRT_DATA_W-1:0]       wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [CRT_DATA_W-1:0]       rdata_o,
  input  wire logic [CRT_NUM_MOD-1:0]      mod_pwm_i,
  input  wire logic [CRT_NUM_MOD-1:0]      mod_en_i,
  input  wire logic [TMR_W-1:0]            cap_a_cnt_i,
  input  wire logic [TMR_W-1:0]            pwm_a_cnt_i,
  input  wire logic [TMR_W-1:0]            cap_b_cnt_i,
  input  wire logic [TMR_W-1:0]            pwm_b_cnt_i,
  output logic      [CRT_NUM_MOD*TMR_W-1:0] tb_value_o,
  output logic      [CRT_NUM_MOD-1:0]      tb_pwm_o,
  output logic      [CRT_NUM_MOD-1:0]      tb_pairb_o,
  output logic      [3:0]                  timer_used_o,
  input  wire logic                        ccp2_pin_select_i,
  input  wire logic                        mcu_mode_i,
  input  wire logic                        ccp2_out_i,
  input  wire logic                        ccp2_oe_i,
  output logic                             ccp2_cap_o,
  input  wire logic                        port_c_line_one_i,
  input  wire logic                        port_e_line_seven_i,
  input  wire logic                        port_e_line_three_i,
  output logic                             port_c_line_one_o,
  output logic                             port_c_line_one_oe_o,
  output logic                             port_e_line_seven_o,
  output logic                             port_e_line_seven_oe_o,
  output logic                             port_e_line_three_o,
  output logic                             port_e_line_three_oe_o
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [1:0]            cur_sel;
  logic [1:0]            next_sel;
  logic                  pin_sel;
  logic                  next_pin_sel;
  logic                  mcu_mode;
  logic                  next_mcu_mode;
  logic                  strap_done;
  logic                  next_strap_done;
  logic [CRT_DATA_W-1:0] next_rdata;
  logic [1:0]            straps_s;

  // straps are static, but still synced; caught once after reset release
  crt_sync2 #(.WIDTH(2)) u_strap_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({mcu_mode_i, ccp2_pin_select_i}),
    .q_o   (straps_s)
  );

  logic [1:0] strap_age;
  logic [1:0] next_strap_age;

  always_comb begin
    next_sel        = cur_sel;
    next_pin_sel    = pin_sel;
    next_mcu_mode   = mcu_mode;
    next_strap_done = strap_done;
    next_strap_age  = strap_age;
    next_rdata      = '0;
    if (wr_i && addr_i == CRT_TMR3_CTRL_OFS) begin
      next_sel = wdata_i[CRT_SEL_MSB:CRT_SEL_LSB];
    end
    // wait for the sync pipe to fill before latching the straps
    if (!strap_done) begin
      if (strap_age == 2'h2) begin
        next_pin_sel    = straps_s[0];
        next_mcu_mode   = straps_s[1];
        next_strap_done = 1'b1;
      end else begin
        next_strap_age = strap_age + 2'h1;
      end
    end
    if (rd_i) begin
      case (addr_i)
        CRT_TMR3_CTRL_OFS: next_rdata[CRT_SEL_MSB:CRT_SEL_LSB] = cur_sel;
        CRT_STATUS_OFS: begin
          next_rdata[CRT_ST_USED_LSB +: 4] = timer_used_o;
          next_rdata[CRT_ST_PIN_BIT]       = pin_sel;
          next_rdata[CRT_ST_MCU_BIT]       = mcu_mode;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_sel    <= CRT_SEL_RST;
      pin_sel    <= CRT_PINSEL_RST;
      mcu_mode   <= 1'b0;
      strap_done <= 1'b0;
      strap_age  <= 2'h0;
      rdata_o    <= '0;
    end else begin
      cur_sel    <= next_sel;
      pin_sel    <= next_pin_sel;
      mcu_mode   <= next_mcu_mode;
      strap_done <= next_strap_done;
      strap_age  <= next_strap_age;
      rdata_o    <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // time base routing
  // ------------------------------------------------------------
  logic [4:0]                     map_pairb;
  logic [3:0]                     map_used;
  logic [CRT_NUM_MOD*TMR_W-1:0]   next_tb_value;

  crt_pair_map u_map (
    .sel_i   (cur_sel),
    .pwm_i   (mod_pwm_i),
    .en_i    (mod_en_i),
    .pairb_o (map_pairb),
    .used_o  (map_used)
  );

  genvar gi;
  generate
    for (gi = 0; gi < CRT_NUM_MOD; gi++) begin : g_mod
      // class picks the timer kind, pair picks a or b
      assign next_tb_value[gi*TMR_W +: TMR_W] =
        mod_pwm_i[gi] ? (map_pairb[gi] ? pwm_b_cnt_i : pwm_a_cnt_i)
                      : (map_pairb[gi] ? cap_b_cnt_i : cap_a_cnt_i);
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tb_value_o   <= '0;
      tb_pwm_o     <= '0;
      tb_pairb_o   <= '0;
      timer_used_o <= '0;
    end else begin
      tb_value_o   <= next_tb_value;
      tb_pwm_o     <= mod_pwm_i;
      tb_pairb_o   <= map_pairb;
      timer_used_o <= map_used;
    end
  end

  // ------------------------------------------------------------
  // second enhanced module pin routing
  // ------------------------------------------------------------
  // oe here only asks for the peripheral override; the port still honours
  // pin_direction_bits, so software must set them for the chosen pin
  crt_pin_t   route;
  logic [2:0] pins_s;
  logic       next_cap;
  logic [2:0] next_pin_out;
  logic [2:0] next_pin_oe;

  crt_sync2 #(.WIDTH(3)) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({port_e_line_three_i, port_e_line_seven_i, port_c_line_one_i}),
    .q_o   (pins_s)
  );

  always_comb begin
    if (pin_sel) begin
      route = crt_pin_c1;
    end else if (mcu_mode) begin
      route = crt_pin_e7;
    end else begin
      route = crt_pin_e3;
    end
    next_pin_out = '0;
    next_pin_oe  = '0;
    case (route)
      crt_pin_c1: begin
        next_cap        = pins_s[0];
        next_pin_out[0] = ccp2_out_i;
        next_pin_oe[0]  = ccp2_oe_i;
      end
      crt_pin_e7: begin
        next_cap        = pins_s[1];
        next_pin_out[1] = ccp2_out_i;
        next_pin_oe[1]  = ccp2_oe_i;
      end
      crt_pin_e3: begin
        next_cap        = pins_s[2];
        next_pin_out[2] = ccp2_out_i;
        next_pin_oe[2]  = ccp2_oe_i;
      end
      default: next_cap = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ccp2_cap_o             <= 1'b0;
      port_c_line_one_o      <= 1'b0;
      port_c_line_one_oe_o   <= 1'b0;
      port_e_line_seven_o    <= 1'b0;
      port_e_line_seven_oe_o <= 1'b0;
      port_e_line_three_o    <= 1'b0;
      port_e_line_three_oe_o <= 1'b0;
    end else begin
      ccp2_cap_o             <= next_cap;
      port_c_line_one_o      <= next_pin_out[0];
      port_c_line_one_oe_o   <= next_pin_oe[0];
      port_e_line_seven_o    <= next_pin_out[1];
      port_e_line_seven_oe_o <= next_pin_oe[1];
      port_e_line_three_o    <= next_pin_out[2];
      port_e_line_three_oe_o <= next_pin_oe[2];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sel_write_a: assert property (wr_i && addr_i == CRT_TMR3_CTRL_OFS |=> cur_sel == $past(wdata_i[2:1]))
    else $error("timer select not loaded by write");
  class_pick_a: assert property (!mod_pwm_i[0] && cur_sel == CRT_SEL_ALL_A
                                 |=> tb_value_o[TMR_W-1:0] == $past(cap_a_cnt_i))
    else $error("capture module not on first capture timer");
  all_first_a: assert property (cur_sel == CRT_SEL_ALL_A |=> tb_pairb_o == 5'h00)
    else $error("all-first config routed a module to second pair");
  no_second_a: assert property (cur_sel == CRT_SEL_ALL_A |=> timer_used_o[3:2] == 2'h0)
    else $error("second pair timer used in all-first config");
  one_split_a: assert property (cur_sel == CRT_SEL_ONE_A |=> tb_pairb_o == 5'h1E)
    else $error("one-split config wrong");
  rest_share_a: assert property (cur_sel == CRT_SEL_ONE_A && mod_pwm_i[4:1] == 4'hF && mod_en_i[4:1] != 4'h0
                                 |=> timer_used_o[CRT_T_PWM_B] && tb_value_o[TMR_W +: TMR_W] == $past(pwm_b_cnt_i))
    else $error("remaining modules do not share second pwm timer");
  two_split_a: assert property (cur_sel == CRT_SEL_TWO_A |=> tb_pairb_o == 5'h1C)
    else $error("two-split config wrong");
  all_second_a: assert property (cur_sel == CRT_SEL_ALL_B |=> tb_pairb_o == 5'h1F)
    else $error("all-second config routed a module to first pair");
  no_first_a: assert property (cur_sel == CRT_SEL_ALL_B |=> timer_used_o[1:0] == 2'h0)
    else $error("first pair timer used in all-second config");
  pin_c1_a: assert property (pin_sel |=> port_c_line_one_o == $past(ccp2_out_i)
                             && !port_e_line_seven_oe_o && !port_e_line_three_oe_o)
    else $error("module two not on port C line one");
  pin_e_a: assert property (!pin_sel && strap_done ##1 !pin_sel
                            |-> port_e_line_seven_oe_o == $past(mcu_mode && ccp2_oe_i)
                            && port_e_line_three_oe_o == $past(!mcu_mode && ccp2_oe_i))
    else $error("module two on wrong port E line");
  share_cnt_a: assert property (cur_sel == CRT_SEL_TWO_A && mod_en_i[1:0] == 2'h3 && mod_pwm_i[1:0] == 2'h0
                                |=> timer_used_o[CRT_T_CAP_A])
    else $error("shared capture timer not marked in use");

  // read port: data stand one cycle only, so a stale value never looks like a fresh read
  rd_idle_a: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data not zero outside a read");
  rd_sel_a: assert property (rd_i && addr_i == CRT_TMR3_CTRL_OFS
                             |=> rdata_o == {5'h00, $past(cur_sel), 1'b0})
    else $error("timer select not read back");
  pwm_class_a: assert property (mod_pwm_i[4] && cur_sel == CRT_SEL_ALL_B
                                |=> tb_value_o[4*TMR_W +: TMR_W] == $past(pwm_b_cnt_i))
    else $error("pwm module not on second pwm timer");
  one_first_a: assert property (!mod_pwm_i[0] && cur_sel == CRT_SEL_ONE_A
                                |=> tb_value_o[TMR_W-1:0] == $past(cap_a_cnt_i))
    else $error("module one not on first capture timer");

  split_one_c: cover property (cur_sel == CRT_SEL_ONE_A ##1 cur_sel == CRT_SEL_TWO_A);
  all_four_c: cover property (timer_used_o == 4'hF);
  pin_e7_c: cover property (port_e_line_seven_oe_o);
  pin_e3_c: cover property (port_e_line_three_oe_o);
  status_rd_c: cover property (rd_i && addr_i == CRT_STATUS_OFS);

endmodule : crt_route_top
`default_nettype wire

// ---- bench/crt_far_model.sv ----
// model of the far side: four free-running timers and the three pads
// assumes one clock shared with the routing block; pads settle within a cycle
`timescale 1ns/100ps
`default_nettype none
module crt_far_model
  import crt_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  output logic      [CRT_TMR_W-1:0] cap_a_o,
  output logic      [CRT_TMR_W-1:0] pwm_a_o,
  output logic      [CRT_TMR_W-1:0] cap_b_o,
  output logic      [CRT_TMR_W-1:0] pwm_b_o,
  input  wire logic [2:0]           pad_out_i,
  input  wire logic [2:0]           pad_oe_i,
  input  wire logic [2:0]           ext_i,
  output logic      [2:0]           pad_o
);
  // ------------------------------------------------------------
  // timers
  // ------------------------------------------------------------
  // distinct offsets so a wrong timer choice never matches by luck
  logic [CRT_TMR_W-1:0] cnt;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  assign cap_a_o = cnt;
  assign pwm_a_o = cnt + 16'h4000;
  assign cap_b_o = cnt + 16'h8000;
  assign pwm_b_o = cnt + 16'hC000;

  // ------------------------------------------------------------
  // pads
  // ------------------------------------------------------------
  // direction is software's job; pad shows the driver or the outside level
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule : crt_far_model
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the timer and pin routing block
// assumes the far model above and the package constants of the design
`timescale 1ns/100ps
`default_nettype none
module tb;
  import crt_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rdata_o;
  logic [4:0]  mod_pwm_i = 5'h00;
  logic [4:0]  mod_en_i = 5'h1F;
  logic [15:0] ca, pa, cb, pb;
  logic [79:0] tb_value_o;
  logic [4:0]  tb_pwm_o, tb_pairb_o;
  logic [3:0]  timer_used_o;
  logic        pin_sel = 1'b1;
  logic        mcu = 1'b0;
  logic        c2_out = 1'b0;
  logic        c2_oe = 1'b0;
  logic        c2_cap;
  logic [2:0]  pad_in, pad_out, pad_oe;
  logic [2:0]  ext = 3'h0;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [3:0]  used;
  logic [4:0]  pat_pwm [4] = '{5'h00, 5'h1F, 5'h05, 5'h1A};
  logic [4:0]  pat_en [4] = '{5'h1F, 5'h1F, 5'h1F, 5'h0A};

  always #25 clk_i = ~clk_i;

  crt_far_model u_crt_far_model (.clk_i(clk_i), .rst_i(rst_i), .cap_a_o(ca), .pwm_a_o(pa), .cap_b_o(cb),
    .pwm_b_o(pb), .pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext), .pad_o(pad_in));

  crt_route_top u_crt_route_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mod_pwm_i(mod_pwm_i), .mod_en_i(mod_en_i),
    .cap_a_cnt_i(ca), .pwm_a_cnt_i(pa), .cap_b_cnt_i(cb), .pwm_b_cnt_i(pb), .tb_value_o(tb_value_o),
    .tb_pwm_o(tb_pwm_o), .tb_pairb_o(tb_pairb_o), .timer_used_o(timer_used_o), .ccp2_pin_select_i(pin_sel),
    .mcu_mode_i(mcu), .ccp2_out_i(c2_out), .ccp2_oe_i(c2_oe), .ccp2_cap_o(c2_cap),
    .port_c_line_one_i(pad_in[2]), .port_e_line_seven_i(pad_in[1]), .port_e_line_three_i(pad_in[0]),
    .port_c_line_one_o(pad_out[2]), .port_c_line_one_oe_o(pad_oe[2]), .port_e_line_seven_o(pad_out[1]),
    .port_e_line_seven_oe_o(pad_oe[1]), .port_e_line_three_o(pad_out[0]), .port_e_line_three_oe_o(pad_oe[0]));

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // register port, called right after a rising edge
  // ------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    chk("read_data", 16'(exp), 16'(rdata_o));
    @(posedge clk_i);
  endtask : rd_reg

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : do_reset

  // ------------------------------------------------------------
  // routing check: module i on the second pair once i reaches the split
  // ------------------------------------------------------------
  task automatic chk_route(input logic [1:0] sel, output logic [3:0] u);
    int          n;
    logic [4:0]  b;
    logic [15:0] exp;
    n = (sel == 2'h0) ? 5 : (sel == 2'h1) ? 1 : (sel == 2'h2) ? 2 : 0;
    u = 4'h0;
    @(negedge clk_i);
    for (int i = 0; i < 5; i++) begin
      b[i] = (i >= n);
      exp  = {b[i], mod_pwm_i[i], 14'h0000} + ca - 16'h0001;
      chk("time_base", exp, tb_value_o[16*i +: 16]);
      if (mod_en_i[i]) u[{b[i], mod_pwm_i[i]}] = 1'b1;
    end
    chk("pair_b", 16'(b), 16'(tb_pairb_o));
    chk("mode_copy", 16'(mod_pwm_i), 16'(tb_pwm_o));
    chk("timers_used", 16'(u), 16'(timer_used_o));
    @(posedge clk_i);
  endtask : chk_route

  // ------------------------------------------------------------
  // pin route: strap, reset, drive out, then capture from the pad
  // ------------------------------------------------------------
  task automatic pin_case(input logic ps, input logic mm, input logic [2:0] hot);
    pin_sel   <= ps;
    mcu       <= mm;
    mod_pwm_i <= 5'h00;
    mod_en_i  <= 5'h1F;
    do_reset();
    c2_out <= 1'b1;
    c2_oe  <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("pin_out", 16'(hot), 16'(pad_out));
    chk("pin_oe", 16'(hot), 16'(pad_oe));
    @(posedge clk_i);
    rd_reg(CRT_STATUS_OFS, {2'b00, mm, ps, 4'h1});
    // low first: the driven pad already sits high, so only a rise from low proves capture
    c2_oe <= 1'b0;
    ext   <= ~hot;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    chk("capture_lo", 16'h0000, 16'(c2_cap));
    @(posedge clk_i);
    ext <= hot;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    chk("capture_hi", 16'h0001, 16'(c2_cap));
    @(posedge clk_i);
  endtask : pin_case

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    rd_reg(CRT_TMR3_CTRL_OFS, 8'h00);
    wr_reg(CRT_TMR3_CTRL_OFS, 8'hFF);
    rd_reg(CRT_TMR3_CTRL_OFS, 8'h06);
    wr_reg(8'h7F, 8'hFF);
    rd_reg(8'h7F, 8'h00);
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 4; m++) begin
        wr_reg(CRT_TMR3_CTRL_OFS, {5'h00, 2'(s), 1'b0});
        mod_pwm_i <= pat_pwm[m];
        mod_en_i  <= pat_en[m];
        repeat (2) @(posedge clk_i);
        chk_route(2'(s), used);
        rd_reg(CRT_STATUS_OFS, {2'b00, 1'b0, 1'b1, used});
      end
    end
    pin_case(1'b1, 1'b0, 3'b100);
    pin_case(1'b0, 1'b1, 3'b010);
    pin_case(1'b0, 1'b0, 3'b001);
    close_out();
  end
endmodule : tb
`default_nettype wire
